// ===== rtl/pwr_irq_ctrl.sv
// Power mode sequencing and interrupt vectoring for a 16-bit controller.
// Assumes CPU, flash and peripherals on SYS_CLK_I; only the NMI and
// reset pins come from outside and are synchronised here.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module pwr_irq_ctrl
    import pwr_irq_pkg::*;
#(
    parameter logic [15:0] RAM_END = 16'h05FF,
    parameter logic [15:0] CODE_START = 16'h8000
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic POR_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic MODE_WR_I,
    input wire logic [2:0] MODE_I,
    input wire logic GIE_I,
    input wire logic IRQ_ACK_I,
    input wire logic RETI_I,
    input wire logic FETCH_I,
    input wire logic [15:0] FETCH_ADDR_I,
    input wire logic [15:0] RESET_VEC_WORD_I,
    input wire logic [15:0] BOOT_KEY_WORD_I,
    input wire logic DCO_USED_I,
    input wire logic WDT_INTERVAL_MODE_I,
    input wire logic WDT_EVENT_I,
    input wire logic KEY_VIOL_I,
    input wire logic OSC_FAULT_I,
    input wire logic ACCV_FLAG_I,
    input wire logic NMI_PIN_I,
    input wire logic RST_PIN_N_I,
    input wire logic TB_CC0_I,
    input wire logic TB_OTHER_I,
    input wire logic TA_CC0_I,
    input wire logic TA_OTHER_I,
    input wire logic SER_RX_I,
    input wire logic SER_TX_I,
    input wire logic CONV_DONE_I,
    input wire logic [7:0] PORT_TWO_FLAGS_I,
    input wire logic [7:0] PORT_ONE_FLAGS_I,
    output logic IRQ_REQ_O,
    output logic [15:0] IRQ_VECTOR_O,
    output logic RESET_REQ_O,
    output logic CPU_RUN_O,
    output logic MCLK_EN_O,
    output logic SUB_MAIN_CLOCK_EN_O,
    output logic ACLK_EN_O,
    output logic DCO_GEN_EN_O,
    output logic XTAL_EN_O,
    output logic BOOT_LOADER_OFF_O,
    output logic BOOT_NO_ERASE_O
);

    // Whole state of the block
    typedef struct packed {
        ctrl_state_e state;
        pwr_mode_e mode;
        logic [STACK_DEPTH-1:0][2:0] stack;
        logic [2:0] depth;
        logic [7:0] ie_one;
        logic [7:0] flag_one;
        logic reset_pend;
        logic wdt_int_pend;
        logic irq_req;
        logic [15:0] irq_vec;
        logic reset_req;
        logic [5:0] clk_en;
        logic bsl_off;
        logic no_erase;
        logic [7:0] rdata;
        logic [2:0] nmi_sync;
        logic [2:0] rst_sync;
    } state_s;

    state_s q;
    state_s d;

    // Vector word address from a priority level
    function automatic logic [15:0] vec_addr(input logic [4:0] prio);
        vec_addr = VEC_BASE + {10'h000, prio, 1'b0};
    endfunction : vec_addr

    // Clock enables {cpu, mclk, sub_main_clock, aclk, dc gen, crystal} per mode
    function automatic logic [5:0] clk_plan(input pwr_mode_e m, input logic dco_used);
        unique case (m)
            MODE_ACTIVE: clk_plan = 6'h3F;
            MODE_LOW_POWER_MODE_0: clk_plan = 6'h0F;
            MODE_LOW_POWER_MODE_1: clk_plan = {4'h3, dco_used, 1'b1};
            MODE_LOW_POWER_MODE_2: clk_plan = 6'h07;
            MODE_LOW_POWER_MODE_3: clk_plan = 6'h05;
            MODE_LOW_POWER_MODE_4: clk_plan = 6'h00;
            default: clk_plan = 6'h3F;
        endcase
    endfunction : clk_plan

    // Fetch from module registers or unmapped space
    function automatic logic fetch_bad(input logic [15:0] a, input logic [15:0] ram_end,
                                       input logic [15:0] code_start);
        logic ok;
        ok = (a >= RAM_START && a <= ram_end) || (a >= BOOT_START && a <= INFO_END) ||
             (a >= code_start);
        fetch_bad = (a <= MOD_REG_END) || !ok;
    endfunction : fetch_bad

    logic nmi_rise;
    logic rst_fall;
    logic wdt_reset_event;
    logic sys_nmi;
    logic [4:0] win_prio;
    logic any_pend;
    logic [31:0] pend;

    always_comb begin
        d = q;
        nmi_rise = q.nmi_sync[1] & ~q.nmi_sync[2];
        rst_fall = ~q.rst_sync[1] & q.rst_sync[2];
        wdt_reset_event = WDT_EVENT_I & ~WDT_INTERVAL_MODE_I;
        d.reset_req = 1'b0;

        // Pin synchronisers, first stage feeds only the second
        d.nmi_sync = {q.nmi_sync[1:0], NMI_PIN_I};
        d.rst_sync = {q.rst_sync[1:0], RST_PIN_N_I};

        if (FETCH_I && q.state == ST_RUN && fetch_bad(FETCH_ADDR_I, RAM_END, CODE_START)) begin
            d.reset_req = 1'b1;
        end
        if (wdt_reset_event || KEY_VIOL_I || rst_fall) begin
            d.reset_req = 1'b1;
        end

        // Software writes to enables and flags
        if (REG_WR_I && REG_ADDR_I == IE_ONE_ADDR) begin
            d.ie_one = REG_WDATA_I & IE_ONE_IMPL;
        end
        if (REG_WR_I && REG_ADDR_I == FLAG_ONE_ADDR) begin
            d.flag_one = REG_WDATA_I & FLAG_ONE_IMPL;
        end

        // Hardware sets win over a software clear in the same cycle
        // watchdog overflow or key fault
        if (wdt_reset_event || KEY_VIOL_I || (WDT_EVENT_I && WDT_INTERVAL_MODE_I)) begin
            d.flag_one[WDT_FLAG_BIT] = 1'b1;
        end
        if (rst_fall) begin
            d.flag_one[WDT_FLAG_BIT] = 1'b0;
            d.flag_one[RST_FLAG_BIT] = 1'b1;
        end
        if (OSC_FAULT_I) begin
            d.flag_one[OFS_FLAG_BIT] = 1'b1;
        end
        if (nmi_rise) begin
            d.flag_one[NMI_FLAG_BIT] = 1'b1;
        end
        if (WDT_EVENT_I && WDT_INTERVAL_MODE_I) begin
            d.wdt_int_pend = 1'b1;
        end

        // system NMI class gated by own enables only
        sys_nmi = (q.flag_one[NMI_FLAG_BIT] & q.ie_one[NMI_IE_BIT]) |
                  (q.flag_one[OFS_FLAG_BIT] & q.ie_one[OFS_IE_BIT]) |
                  (ACCV_FLAG_I & q.ie_one[ACCV_IE_BIT]);

        // Pending levels by priority, maskable ones need the general enable
        pend = 32'h0000_0000;
        pend[PRIO_RESET] = q.reset_pend;
        pend[PRIO_SYS_NMI] = sys_nmi;
        pend[PRIO_TB_CC0] = GIE_I & TB_CC0_I;
        pend[PRIO_TB_OTHER] = GIE_I & TB_OTHER_I;
        // enable counts only in interval mode
        pend[PRIO_WDT] = GIE_I & q.wdt_int_pend & q.ie_one[WDT_IE_BIT] & WDT_INTERVAL_MODE_I;
        pend[PRIO_TA_CC0] = GIE_I & TA_CC0_I;
        pend[PRIO_TA_OTHER] = GIE_I & TA_OTHER_I;
        pend[PRIO_SER_RX] = GIE_I & SER_RX_I;
        pend[PRIO_SER_TX] = GIE_I & SER_TX_I;
        pend[PRIO_CONV] = GIE_I & CONV_DONE_I;
        pend[PRIO_PORT_TWO] = GIE_I & (|PORT_TWO_FLAGS_I);
        pend[PRIO_PORT_ONE] = GIE_I & (|PORT_ONE_FLAGS_I);
        // levels below 16 never raise a vector

        win_prio = 5'h00;
        any_pend = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (pend[i]) begin
                win_prio = i[4:0];
                any_pend = 1'b1;
            end
        end

        unique case (q.state)
            ST_BOOT: begin
                // key AA55 turns boot loader off
                d.bsl_off = (BOOT_KEY_WORD_I == BOOT_KEY_OFF);
                // key zero keeps flash on bad password
                d.no_erase = (BOOT_KEY_WORD_I == BOOT_KEY_NO_ERASE);
                // blank reset vector parks in mode 4
                if (RESET_VEC_WORD_I == BLANK_WORD) begin
                    d.state = ST_HALT;
                    d.mode = MODE_LOW_POWER_MODE_4;
                end else begin
                    d.state = ST_RUN;
                    d.reset_pend = 1'b1;
                end
            end
            ST_RUN: begin
                // software selects mode through status bits
                if (MODE_WR_I) begin
                    d.mode = pwr_mode_e'(MODE_I);
                end
                if (IRQ_ACK_I && q.irq_req) begin
                    if (q.depth != STACK_FULL) begin
                        d.stack[q.depth[1:0]] = q.mode;
                        d.depth = q.depth + 3'h1;
                    end
                    d.mode = MODE_ACTIVE;
                    if (q.irq_vec == RESET_VEC_ADDR) begin
                        d.reset_pend = 1'b0;
                    end
                    if (q.irq_vec == vec_addr(PRIO_WDT)) begin
                        d.wdt_int_pend = 1'b0;
                    end
                end else if (RETI_I) begin
                    if (q.depth != 3'h0) begin
                        d.mode = pwr_mode_e'(q.stack[q.depth[1:0] - 2'h1]);
                        d.depth = q.depth - 3'h1;
                    end else begin
                        d.mode = MODE_ACTIVE;
                    end
                end
            end
            ST_HALT: begin
                d.mode = MODE_LOW_POWER_MODE_4;
            end
            default: begin
                d.state = ST_BOOT;
            end
        endcase

        // request carries the vector word address
        d.irq_req = (q.state == ST_RUN) && any_pend && !(IRQ_ACK_I && q.irq_req);
        d.irq_vec = any_pend ? vec_addr(win_prio) : VEC_TOP;
        d.clk_en = clk_plan(d.mode, DCO_USED_I);

        // Register read port, data one cycle after the strobe
        d.rdata = 8'h00;
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                IE_ONE_ADDR: d.rdata = q.ie_one;
                FLAG_ONE_ADDR: d.rdata = q.flag_one;
                MODE_STAT_ADDR: d.rdata = {q.state, q.depth, q.mode};
                VEC_STAT_ADDR: d.rdata = q.irq_vec[7:0];
                default: d.rdata = 8'h00;
            endcase
        end

        if (RST_I || POR_I) begin
            d.state = ST_BOOT;
            d.mode = MODE_ACTIVE;
            d.stack = '0;
            d.depth = 3'h0;
            d.ie_one = IE_ONE_PUC;
            d.flag_one[OFS_FLAG_BIT] = 1'b1;
            d.flag_one[NMI_FLAG_BIT] = 1'b0;
            d.reset_pend = 1'b0;
            d.wdt_int_pend = 1'b0;
            d.irq_req = 1'b0;
            d.irq_vec = VEC_TOP;
            d.reset_req = 1'b0;
            d.clk_en = clk_plan(MODE_ACTIVE, 1'b1);
            d.bsl_off = 1'b0;
            d.no_erase = 1'b0;
            d.rdata = 8'h00;
        end
        if (POR_I) begin
            d.flag_one[WDT_FLAG_BIT] = 1'b0;
            d.flag_one[RST_FLAG_BIT] = 1'b0;
            d.flag_one[POR_FLAG_BIT] = 1'b1;
            d.nmi_sync = 3'h0;
            d.rst_sync = 3'h7;
        end
    end

    // State register
    always_ff @(posedge SYS_CLK_I) begin
        q <= d;
    end

    // Outputs straight from state
    assign REG_RDATA_O = q.rdata;
    assign IRQ_REQ_O = q.irq_req;
    assign IRQ_VECTOR_O = q.irq_vec;
    assign RESET_REQ_O = q.reset_req;
    assign CPU_RUN_O = q.clk_en[5];
    assign MCLK_EN_O = q.clk_en[4];
    assign SUB_MAIN_CLOCK_EN_O = q.clk_en[3];
    assign ACLK_EN_O = q.clk_en[2];
    assign DCO_GEN_EN_O = q.clk_en[1];
    assign XTAL_EN_O = q.clk_en[0];
    assign BOOT_LOADER_OFF_O = q.bsl_off;
    assign BOOT_NO_ERASE_O = q.no_erase;

endmodule : pwr_irq_ctrl

// ===== rtl/pwr_irq_pkg.sv
// Package for the power mode and interrupt vectoring block.
// Assumes one system clock and a byte-wide register port.
package pwr_irq_pkg;

    // Register indices on the byte-wide register port
    localparam logic [7:0] IE_ONE_ADDR = 8'h00;
    localparam logic [7:0] FLAG_ONE_ADDR = 8'h02;
    localparam logic [7:0] MODE_STAT_ADDR = 8'h04;
    localparam logic [7:0] VEC_STAT_ADDR = 8'h05;

    // Enable register field positions
    localparam int WDT_IE_BIT = 0;
    localparam int OFS_IE_BIT = 1;
    localparam int NMI_IE_BIT = 4;
    localparam int ACCV_IE_BIT = 5;
    localparam logic [7:0] IE_ONE_IMPL = 8'h33;
    localparam logic [7:0] IE_ONE_PUC = 8'h00;

    // Flag register field positions
    localparam int WDT_FLAG_BIT = 0;
    localparam int OFS_FLAG_BIT = 1;
    localparam int POR_FLAG_BIT = 2;
    localparam int RST_FLAG_BIT = 3;
    localparam int NMI_FLAG_BIT = 4;
    localparam logic [7:0] FLAG_ONE_IMPL = 8'h1F;

    // Vector table
    localparam logic [15:0] VEC_BASE = 16'hFFC0;
    localparam logic [15:0] VEC_TOP = 16'hFFFF;
    localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
    localparam logic [15:0] BOOT_KEY_ADDR = 16'hFFDE;
    localparam logic [15:0] BOOT_KEY_OFF = 16'hAA55;
    localparam logic [15:0] BOOT_KEY_NO_ERASE = 16'h0000;
    localparam logic [15:0] BLANK_WORD = 16'hFFFF;

    // Priorities of the served vectors
    localparam logic [4:0] PRIO_RESET = 5'h1F;
    localparam logic [4:0] PRIO_SYS_NMI = 5'h1E;
    localparam logic [4:0] PRIO_TB_CC0 = 5'h1D;
    localparam logic [4:0] PRIO_TB_OTHER = 5'h1C;
    localparam logic [4:0] PRIO_WDT = 5'h1A;
    localparam logic [4:0] PRIO_TA_CC0 = 5'h19;
    localparam logic [4:0] PRIO_TA_OTHER = 5'h18;
    localparam logic [4:0] PRIO_SER_RX = 5'h17;
    localparam logic [4:0] PRIO_SER_TX = 5'h16;
    localparam logic [4:0] PRIO_CONV = 5'h15;
    localparam logic [4:0] PRIO_PORT_TWO = 5'h13;
    localparam logic [4:0] PRIO_PORT_ONE = 5'h12;

    // Address map used by the fetch check
    localparam logic [15:0] MOD_REG_END = 16'h01FF;
    localparam logic [15:0] RAM_START = 16'h0200;
    localparam logic [15:0] BOOT_START = 16'h0C00;
    localparam logic [15:0] INFO_END = 16'h10FF;

    // Saved mode stack
    localparam int STACK_DEPTH = 4;
    localparam logic [2:0] STACK_FULL = 3'h4;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b000,
        MODE_LOW_POWER_MODE_0 = 3'b001,
        MODE_LOW_POWER_MODE_1 = 3'b010,
        MODE_LOW_POWER_MODE_2 = 3'b011,
        MODE_LOW_POWER_MODE_3 = 3'b100,
        MODE_LOW_POWER_MODE_4 = 3'b101
    } pwr_mode_e;

    // Control states
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_RUN = 2'b01,
        ST_HALT = 2'b10
    } ctrl_state_e;

endpackage : pwr_irq_pkg

// ===== testbench/pwr_irq_ctrl_asserts.sv
// Port checker for the power mode and interrupt block.
// Assumes registered outputs and synchronous active-high resets.
`timescale 1ns/1ns
module pwr_irq_ctrl_asserts
    import pwr_irq_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic POR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic MODE_WR_I,
    input wire logic [2:0] MODE_I,
    input wire logic IRQ_ACK_I,
    input wire logic DCO_USED_I,
    input wire logic KEY_VIOL_I,
    input wire logic FETCH_I,
    input wire logic [15:0] FETCH_ADDR_I,
    input wire logic IRQ_REQ_O,
    input wire logic [15:0] IRQ_VECTOR_O,
    input wire logic RESET_REQ_O,
    input wire logic CPU_RUN_O,
    input wire logic MCLK_EN_O,
    input wire logic SUB_MAIN_CLOCK_EN_O,
    input wire logic ACLK_EN_O,
    input wire logic DCO_GEN_EN_O,
    input wire logic XTAL_EN_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I || POR_I);

    a_active_clocks_on: assert property (MODE_WR_I && MODE_I == MODE_ACTIVE && !IRQ_ACK_I
        |=> CPU_RUN_O && MCLK_EN_O && SUB_MAIN_CLOCK_EN_O && ACLK_EN_O) else $error("active clocks off");
    a_mode0_cpu_off: assert property (MODE_WR_I && MODE_I == MODE_LOW_POWER_MODE_0 && !IRQ_ACK_I
        |=> !CPU_RUN_O && !MCLK_EN_O && SUB_MAIN_CLOCK_EN_O && ACLK_EN_O) else $error("mode 0 clocks");
    a_mode1_gen_use: assert property (MODE_WR_I && MODE_I == MODE_LOW_POWER_MODE_1 && !IRQ_ACK_I
        |=> DCO_GEN_EN_O == $past(DCO_USED_I)) else $error("mode 1 generator");
    a_mode2_gen_on: assert property (MODE_WR_I && MODE_I == MODE_LOW_POWER_MODE_2 && !IRQ_ACK_I
        |=> !SUB_MAIN_CLOCK_EN_O && ACLK_EN_O && DCO_GEN_EN_O) else $error("mode 2 clocks");
    a_mode3_gen_off: assert property (MODE_WR_I && MODE_I == MODE_LOW_POWER_MODE_3 && !IRQ_ACK_I
        |=> !SUB_MAIN_CLOCK_EN_O && ACLK_EN_O && !DCO_GEN_EN_O) else $error("mode 3 clocks");
    a_mode4_all_off: assert property (MODE_WR_I && MODE_I == MODE_LOW_POWER_MODE_4 && !IRQ_ACK_I
        |=> !ACLK_EN_O && !SUB_MAIN_CLOCK_EN_O && !DCO_GEN_EN_O && !XTAL_EN_O) else $error("mode 4 clocks");
    a_ack_wakes_cpu: assert property (IRQ_ACK_I && IRQ_REQ_O
        |=> CPU_RUN_O && MCLK_EN_O && !IRQ_REQ_O) else $error("no wake on ack");
    a_vector_in_table: assert property (IRQ_REQ_O
        |-> IRQ_VECTOR_O >= 16'hFFE4 && !IRQ_VECTOR_O[0]) else $error("vector out of table");
    a_bad_fetch_reset: assert property (FETCH_I && FETCH_ADDR_I <= MOD_REG_END && CPU_RUN_O
        |=> RESET_REQ_O) else $error("no reset on bad fetch");
    a_key_fault_reset: assert property (KEY_VIOL_I |=> RESET_REQ_O)
        else $error("no reset on key fault");
    a_read_data_idle: assert property ($past(REG_RD_I) == 1'b0 |-> REG_RDATA_O == 8'h00)
        else $error("read data outside slot");
endmodule : pwr_irq_ctrl_asserts

// ===== testbench/cpu_side_model.sv
// CPU side model: takes interrupt requests after a settable delay.
// Assumes the block holds its request until it is taken.
`timescale 1ns/1ns
module cpu_side_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic [3:0] delay_i,
    input wire logic req_i,
    output logic ack_o
);
    logic [3:0] wait_q;

    // Count request cycles, then take it with a one-cycle pulse
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        if (rst_i || !en_i || !req_i || ack_o) begin
            wait_q <= 4'h0;
        end else if (wait_q >= delay_i) begin
            ack_o <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : cpu_side_model

// ===== testbench/pwr_irq_ctrl_test.sv
// Self-checking bench for the power mode and interrupt block.
// Assumes the CPU model takes requests; the bench drives everything else.
`timescale 1ns/1ns
module pwr_irq_ctrl_test
    import pwr_irq_pkg::*;
;
    logic clk = 0, rst = 1, por = 1, wr_s = 0, rd_s = 0, mode_wr = 0, gie = 0, reti = 0;
    logic fetch = 0, dco_used = 0, wdt_int = 0, wdt_ev = 0, key_v = 0, accv = 0, nmi = 0;
    logic cpu_en = 0, ack, irq_req, reset_req, boot_off, no_erase, rst_pin = 1;
    logic [2:0] mode = 3'h0;
    logic [3:0] cpu_dly = 4'h0;
    logic [5:0] en6;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [8:0] src = 9'h000;
    logic [15:0] faddr = 16'h8000, vec_w = 16'h8000, key_w = 16'h0000, irq_vec;
    int errors = 0, checks_done = 0, cycles = 0;

    pwr_irq_ctrl i_dut (.SYS_CLK_I(clk), .RST_I(rst), .POR_I(por), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
        .MODE_WR_I(mode_wr), .MODE_I(mode), .GIE_I(gie), .IRQ_ACK_I(ack), .RETI_I(reti),
        .FETCH_I(fetch), .FETCH_ADDR_I(faddr), .RESET_VEC_WORD_I(vec_w),
        .BOOT_KEY_WORD_I(key_w), .DCO_USED_I(dco_used), .WDT_INTERVAL_MODE_I(wdt_int),
        .WDT_EVENT_I(wdt_ev), .KEY_VIOL_I(key_v), .OSC_FAULT_I(1'b0), .ACCV_FLAG_I(accv),
        .NMI_PIN_I(nmi), .RST_PIN_N_I(rst_pin), .TB_CC0_I(src[8]), .TB_OTHER_I(src[7]),
        .TA_CC0_I(src[6]), .TA_OTHER_I(src[5]), .SER_RX_I(src[4]), .SER_TX_I(src[3]),
        .CONV_DONE_I(src[2]), .PORT_TWO_FLAGS_I({src[1], 7'h00}),
        .PORT_ONE_FLAGS_I({7'h00, src[0]}), .IRQ_REQ_O(irq_req), .IRQ_VECTOR_O(irq_vec),
        .RESET_REQ_O(reset_req), .CPU_RUN_O(en6[5]), .MCLK_EN_O(en6[4]), .SUB_MAIN_CLOCK_EN_O(en6[3]),
        .ACLK_EN_O(en6[2]), .DCO_GEN_EN_O(en6[1]), .XTAL_EN_O(en6[0]),
        .BOOT_LOADER_OFF_O(boot_off), .BOOT_NO_ERASE_O(no_erase));

    cpu_side_model i_cpu (.clk_i(clk), .rst_i(rst), .en_i(cpu_en), .delay_i(cpu_dly),
        .req_i(irq_req), .ack_o(ack));

    // Clock and hang guard
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd

    task automatic set_mode(input logic [2:0] m);
        @(posedge clk);
        mode <= m;
        mode_wr <= 1'b1;
        @(posedge clk);
        mode_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask : set_mode

    // One pulse of {watchdog event, key fault, fetch}, then the reset request
    task automatic req_case(input logic [2:0] k, input logic [15:0] fa, input logic exp);
        @(posedge clk);
        {wdt_ev, key_v, fetch} <= k;
        faddr <= fa;
        @(posedge clk);
        {wdt_ev, key_v, fetch} <= 3'b000;
        #1 check(reset_req, exp);
    endtask : req_case

    task automatic rst_run(input logic [15:0] vw, input logic [15:0] kw, input logic p);
        @(posedge clk);
        {rst, por, vec_w, key_w} <= {1'b1, p, vw, kw};
        cyc(6);
        {rst, por} <= 2'b00;
        cyc(4);
        #1 check({boot_off, no_erase}, {kw == BOOT_KEY_OFF, kw == BOOT_KEY_NO_ERASE});
        if (vw == BLANK_WORD) begin
            check({irq_req, en6}, 7'h00);
        end else begin
            check({irq_req, irq_vec}, {1'b1, RESET_VEC_ADDR});
            @(posedge clk);
            cpu_en <= 1'b1;
            cyc(5);
            #1 check(irq_req, 1'b0);
            @(posedge clk);
            cpu_en <= 1'b0;
        end
    endtask : rst_run

    task automatic modes_test();
        logic [5:0] exp [6] = '{6'h3F, 6'h0F, 6'h0D, 6'h07, 6'h05, 6'h00};
        for (int m = 1; m <= 6; m++) begin
            set_mode(3'(m % 6));
            check(en6, exp[m % 6]);
        end
        @(posedge clk);
        dco_used <= 1'b1;
        set_mode(MODE_LOW_POWER_MODE_1);
        check(en6, 6'h0F);
        set_mode(MODE_ACTIVE);
    endtask : modes_test

    task automatic prio_test();
        logic [15:0] vecs [9] = '{16'hFFFA, 16'hFFF8, 16'hFFF2, 16'hFFF0, 16'hFFEE,
            16'hFFEC, 16'hFFEA, 16'hFFE6, 16'hFFE4};
        @(posedge clk);
        src <= 9'h1FF;
        cyc(3);
        #1 check(irq_req, 1'b0);
        @(posedge clk);
        gie <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            cyc(2);
            #1 check({irq_req, irq_vec}, {1'b1, vecs[i]});
            @(posedge clk);
            src[8 - i] <= 1'b0;
        end
        cyc(3);
        #1 check(irq_req, 1'b0);
    endtask : prio_test

    // Wake from mode 3 on a slow take, then return to mode 3
    task automatic wake_test();
        set_mode(MODE_LOW_POWER_MODE_3);
        @(posedge clk);
        {cpu_dly, cpu_en, src[6]} <= {4'h4, 1'b1, 1'b1};
        cyc(10);
        #1 check(en6, 6'h3F);
        @(posedge clk);
        {cpu_en, src[6]} <= 2'b00;
        cyc(3);
        reti <= 1'b1;
        @(posedge clk);
        reti <= 1'b0;
        cyc(2);
        #1 check(en6, 6'h05);
        set_mode(MODE_ACTIVE);
    endtask : wake_test

    task automatic nmi_test();
        @(posedge clk);
        {gie, nmi, cpu_dly} <= {1'b0, 1'b1, 4'h0};
        cyc(5);
        #1 check(irq_req, 1'b0);
        rd(FLAG_ONE_ADDR, 8'h16);
        wr(IE_ONE_ADDR, 8'h10);
        cyc(2);
        #1 check({irq_req, irq_vec}, {1'b1, 16'hFFFC});
        wr(IE_ONE_ADDR, 8'h20);
        wr(FLAG_ONE_ADDR, 8'h00);
        accv <= 1'b1;
        cyc(3);
        #1 check({irq_req, irq_vec}, {1'b1, 16'hFFFC});
        wr(IE_ONE_ADDR, 8'h00);
        {accv, nmi} <= 2'b00;
        cyc(3);
        #1 check(irq_req, 1'b0);
    endtask : nmi_test

    task automatic resets_test();
        req_case(3'b100, 16'h8000, 1'b1);
        rd(FLAG_ONE_ADDR, 8'h01);
        req_case(3'b010, 16'h8000, 1'b1);
        req_case(3'b001, 16'h0100, 1'b1);
        req_case(3'b001, 16'h0700, 1'b1);
        req_case(3'b001, 16'hFFD0, 1'b0);
        {wdt_int, gie} <= 2'b11;
        req_case(3'b100, 16'h8000, 1'b0);
        cyc(2);
        #1 check(irq_req, 1'b0);
        wr(IE_ONE_ADDR, 8'h01);
        req_case(3'b100, 16'h8000, 1'b0);
        cyc(2);
        #1 check({irq_req, irq_vec}, {1'b1, 16'hFFF4});
        @(posedge clk);
        cpu_en <= 1'b1;
        cyc(4);
        #1 check(irq_req, 1'b0);
        @(posedge clk);
        {cpu_en, gie, wdt_int} <= 3'b000;
        // External pin reset clears the watchdog flag and marks itself
        rst_pin <= 1'b0;
        cyc(5);
        rd(FLAG_ONE_ADDR, 8'h08);
        rst_pin <= 1'b1;
    endtask : resets_test

    // Main sequence
    initial begin
        rst_run(BLANK_WORD, BOOT_KEY_OFF, 1'b1);
        rst_run(16'h8000, BOOT_KEY_NO_ERASE, 1'b1);
        rd(IE_ONE_ADDR, IE_ONE_PUC);
        rd(FLAG_ONE_ADDR, 8'h06);
        wr(IE_ONE_ADDR, 8'hFF);
        rd(IE_ONE_ADDR, IE_ONE_IMPL);
        wr(IE_ONE_ADDR, 8'h00);
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h00);
        modes_test();
        prio_test();
        wake_test();
        nmi_test();
        resets_test();
        rst_run(16'h8000, 16'h1234, 1'b0);
        rd(FLAG_ONE_ADDR, 8'h0A);
        summarize();
    end
endmodule : pwr_irq_ctrl_test

bind pwr_irq_ctrl pwr_irq_ctrl_asserts i_chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
    .POR_I(POR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .MODE_WR_I(MODE_WR_I),
    .MODE_I(MODE_I), .IRQ_ACK_I(IRQ_ACK_I), .DCO_USED_I(DCO_USED_I), .KEY_VIOL_I(KEY_VIOL_I),
    .FETCH_I(FETCH_I), .FETCH_ADDR_I(FETCH_ADDR_I), .IRQ_REQ_O(IRQ_REQ_O),
    .IRQ_VECTOR_O(IRQ_VECTOR_O), .RESET_REQ_O(RESET_REQ_O), .CPU_RUN_O(CPU_RUN_O),
    .MCLK_EN_O(MCLK_EN_O), .SUB_MAIN_CLOCK_EN_O(SUB_MAIN_CLOCK_EN_O), .ACLK_EN_O(ACLK_EN_O),
    .DCO_GEN_EN_O(DCO_GEN_EN_O), .XTAL_EN_O(XTAL_EN_O));
